// ==== verilog/umes_map.vh ====
// constants for the serial mode and receive-error status channel
// assumes a 32-bit axi4-lite slave, byte address = 4 * register index
`ifndef UMES_MAP_VH
`define UMES_MAP_VH
// register indices
`define UMES_MODE0_IDX   32'h0FFF_FA00
`define UMES_FLAGS0_IDX  32'hFFFF_FA03
`define UMES_MODE1_IDX   32'hFFFF_FA10
`define UMES_FLAGS1_IDX  32'hFFFF_FA13
`define UMES_TXB0_IDX    32'h0000_0001
`define UMES_RXB0_IDX    32'h0000_0002
`define UMES_TXB1_IDX    32'h0000_0011
`define UMES_RXB1_IDX    32'h0000_0012
// mode register fields
`define UMES_GATE_BIT    7
`define UMES_TXE_BIT     6
`define UMES_RXE_BIT     5
`define UMES_PAR_HI      4
`define UMES_PAR_LO      3
`define UMES_CL_BIT      2
`define UMES_SL_BIT      1
`define UMES_ISRM_BIT    0
// error flag fields
`define UMES_PE_BIT      2
`define UMES_FE_BIT      1
`define UMES_OVE_BIT     0
// reset values
`define UMES_MODE_RST    8'h01
`define UMES_FLAGS_RST   3'h0
`define UMES_BUF_RST     8'hFF
// bus responses
`define UMES_RESP_OKAY   2'h0
`define UMES_RESP_SLVERR 2'h2
// default oversampling ticks per bit
`define UMES_OVS         16
`endif

// ==== verilog/umes_channel.v ====
// one serial channel: mode control, error flags, receiver and transmitter
// assumes an axi4-lite master on clk and a base tick pulse from a baud generator
`timescale 1ns/1ns
`include "umes_map.vh"
module umes_channel #(
  parameter        ADDR_W    = 8,
  parameter        OVS       = `UMES_OVS,
  parameter [31:0] MODE_IDX  = `UMES_MODE0_IDX,
  parameter [31:0] FLAGS_IDX = `UMES_FLAGS0_IDX,
  parameter [31:0] TXB_IDX   = `UMES_TXB0_IDX,
  parameter [31:0] RXB_IDX   = `UMES_RXB0_IDX
) (
  // system
  input  wire              clk,
  input  wire              resetn,
  // base clock tick from the baud generator
  input  wire              baseTick,
  // axi write address
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  // axi write data
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  // axi write response
  output wire              s_axi_bvalid,
  input  wire              s_axi_bready,
  output wire [1:0]        s_axi_bresp,
  // axi read address
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  // axi read data
  input  wire              s_axi_rvalid_unused_n,
  output wire              s_axi_rvalid,
  input  wire              s_axi_rready,
  output wire [31:0]       s_axi_rdata,
  output wire [1:0]        s_axi_rresp,
  // serial pins
  input  wire              serialInPin,
  output wire              serialOutPin,
  // event pulses
  output wire              receiveCompleteIrq,
  output wire              receiveErrorIrq,
  output wire              transmitCompleteIrq
);

  // register selects
  localparam [2:0] SEL_NONE  = 3'h0;
  localparam [2:0] SEL_MODE  = 3'h1;
  localparam [2:0] SEL_FLAGS = 3'h2;
  localparam [2:0] SEL_TXB   = 3'h3;
  localparam [2:0] SEL_RXB   = 3'h4;
  // sequencer states shared by receiver and transmitter
  localparam [2:0] S_IDLE    = 3'h0;
  localparam [2:0] S_START   = 3'h1;
  localparam [2:0] S_DATA    = 3'h2;
  localparam [2:0] S_PAR     = 3'h3;
  localparam [2:0] S_STOP    = 3'h4;
  // ovs is cut to the 8-bit tick counters on purpose
  localparam [31:0] OVS_W    = OVS;
  localparam [7:0] OVS_M1    = OVS_W[7:0] - 8'h01;
  localparam [7:0] HALF_M1   = OVS_W[8:1] - 8'h01;

  // register decode shared by read and write paths
  function [2:0] regSel;
    input [ADDR_W-1:0] a;
    begin
      if (a[1:0] != 2'h0) regSel = SEL_NONE;
      else if (a[ADDR_W-1:2] == MODE_IDX[ADDR_W-3:0]) regSel = SEL_MODE;
      else if (a[ADDR_W-1:2] == FLAGS_IDX[ADDR_W-3:0]) regSel = SEL_FLAGS;
      else if (a[ADDR_W-1:2] == TXB_IDX[ADDR_W-3:0]) regSel = SEL_TXB;
      else if (a[ADDR_W-1:2] == RXB_IDX[ADDR_W-3:0]) regSel = SEL_RXB;
      else regSel = SEL_NONE;
    end
  endfunction

  // bus, register and sequencer state
  reg              awHeld_q;
  reg              wHeld_q;
  reg [ADDR_W-1:0] awAddr_q;
  reg [7:0]        wData_q;
  reg              wStrb0_q;
  reg              bvalid_q;
  reg [1:0]        bresp_q;
  reg              rvalid_q;
  reg [31:0]       rdata_q;
  reg [1:0]        rresp_q;
  reg [7:0]        mode_q;
  reg [2:0]        flags_q;
  reg [7:0]        rxBuf_q;
  reg              rxBufFull_q;
  reg              rxSync1_q;
  reg              rxSync2_q;
  reg [2:0]        rxState_q;
  reg [7:0]        rxCnt_q;
  reg [2:0]        rxBit_q;
  reg [7:0]        rxShift_q;
  reg              rxPar_q;
  reg              rxDoneIrq_q;
  reg              rxErrIrq_q;
  reg [7:0]        txBuf_q;
  reg              txBufFull_q;
  reg [2:0]        txState_q;
  reg [7:0]        txCnt_q;
  reg [2:0]        txBit_q;
  reg [7:0]        txShift_q;
  reg              txPar_q;
  reg              txStop_q;
  reg              txLine_q;
  reg              txDoneIrq_q;

  // mode field decode
  wire       gateOn  = mode_q[`UMES_GATE_BIT];
  wire       txOn    = gateOn & mode_q[`UMES_TXE_BIT];
  wire       rxOn    = gateOn & mode_q[`UMES_RXE_BIT];
  wire [1:0] parSel  = {mode_q[`UMES_PAR_HI], mode_q[`UMES_PAR_LO]};
  wire       len8    = mode_q[`UMES_CL_BIT];
  wire [2:0] lastBit = len8 ? 3'h7 : 3'h6;

  // write and read channel handshakes
  assign s_axi_awready = ~awHeld_q & ~bvalid_q;
  assign s_axi_wready  = ~wHeld_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  wire       doWrite  = awHeld_q & wHeld_q;
  wire [2:0] wSel     = regSel(awAddr_q);
  wire       modeWr   = doWrite & wStrb0_q & (wSel == SEL_MODE);
  wire       txbWrite = doWrite & wStrb0_q & (wSel == SEL_TXB) & txOn;
  wire       doRead   = s_axi_arvalid & ~rvalid_q;
  wire [2:0] rSel     = regSel(s_axi_araddr);
  wire       flagsRd  = doRead & (rSel == SEL_FLAGS);
  wire       rxbRd    = doRead & (rSel == SEL_RXB);

  // capture write address and data in either order, answer once both held
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= {ADDR_W{1'b0}};
      wData_q  <= 8'h00;
      wStrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= `UMES_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q  <= 1'b1;
        wData_q  <= s_axi_wdata[7:0];
        wStrb0_q <= s_axi_wstrb[0];
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= (wSel == SEL_NONE) ? `UMES_RESP_SLVERR : `UMES_RESP_OKAY;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read path, one cycle after the address is taken
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `UMES_RESP_OKAY;
    end else if (doRead) begin
      rvalid_q <= 1'b1;
      rresp_q  <= `UMES_RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
      if (rSel == SEL_MODE) rdata_q[7:0] <= mode_q;
      else if (rSel == SEL_FLAGS) rdata_q[2:0] <= flags_q;
      else if (rSel == SEL_TXB) rdata_q[7:0] <= txBuf_q;
      else if (rSel == SEL_RXB) rdata_q[7:0] <= rxBuf_q;
      else rresp_q <= `UMES_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // mode register
  always @(posedge clk or negedge resetn) begin
    if (!resetn) mode_q <= `UMES_MODE_RST;
    else if (modeWr) mode_q <= wData_q;
  end

  // serial input synchroniser
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxSync1_q <= 1'b1;
      rxSync2_q <= 1'b1;
    end else begin
      rxSync1_q <= serialInPin;
      rxSync2_q <= rxSync1_q;
    end
  end

  wire       rxIn     = rxSync2_q;
  wire       frameEnd = rxOn & baseTick & (rxState_q == S_STOP) & (rxCnt_q == OVS_M1);
  wire [7:0] rxData   = len8 ? rxShift_q : {1'b0, rxShift_q[7:1]};
  wire       peNow    = frameEnd & parSel[1] & ((^rxData ^ rxPar_q) == parSel[0]);
  wire       feNow    = frameEnd & ~rxIn;
  wire       oveNow   = frameEnd & rxBufFull_q & ~rxbRd;
  wire       anyErr   = peNow | feNow | oveNow;

  // receive sequencer, idle while disabled
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxState_q <= S_IDLE;
      rxCnt_q   <= 8'h00;
      rxBit_q   <= 3'h0;
      rxShift_q <= 8'h00;
      rxPar_q   <= 1'b0;
    end else if (!rxOn) begin
      rxState_q <= S_IDLE;
      rxCnt_q   <= 8'h00;
    end else if (baseTick) begin
      case (rxState_q)
        S_IDLE: begin
          rxCnt_q <= 8'h00;
          if (!rxIn) rxState_q <= S_START;
        end
        S_START: begin
          if (rxCnt_q == HALF_M1) begin
            rxCnt_q   <= 8'h00;
            rxBit_q   <= 3'h0;
            rxState_q <= rxIn ? S_IDLE : S_DATA;
          end else rxCnt_q <= rxCnt_q + 8'h01;
        end
        S_DATA: begin
          if (rxCnt_q == OVS_M1) begin
            rxCnt_q   <= 8'h00;
            rxShift_q <= {rxIn, rxShift_q[7:1]};
            rxBit_q   <= rxBit_q + 3'h1;
            if (rxBit_q == lastBit) rxState_q <= (parSel == 2'h0) ? S_STOP : S_PAR;
          end else rxCnt_q <= rxCnt_q + 8'h01;
        end
        S_PAR: begin
          if (rxCnt_q == OVS_M1) begin
            rxCnt_q   <= 8'h00;
            rxPar_q   <= rxIn;
            rxState_q <= S_STOP;
          end else rxCnt_q <= rxCnt_q + 8'h01;
        end
        S_STOP: begin
          if (rxCnt_q == OVS_M1) rxState_q <= S_IDLE;
          else rxCnt_q <= rxCnt_q + 8'h01;
        end
        default: rxState_q <= S_IDLE;
      endcase
    end
  end

  // receive buffer, flags and receive events
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxBuf_q     <= `UMES_BUF_RST;
      rxBufFull_q <= 1'b0;
      flags_q     <= `UMES_FLAGS_RST;
      rxDoneIrq_q <= 1'b0;
      rxErrIrq_q  <= 1'b0;
    end else begin
      if (!gateOn) rxBuf_q <= `UMES_BUF_RST;
      else if (frameEnd && !oveNow) rxBuf_q <= rxData;
      if (!rxOn) rxBufFull_q <= 1'b0;
      else if (frameEnd && !oveNow) rxBufFull_q <= 1'b1;
      else if (rxbRd) rxBufFull_q <= 1'b0;
      // set wins over the read clear
      if (!rxOn) flags_q <= `UMES_FLAGS_RST;
      else flags_q <= (flagsRd ? `UMES_FLAGS_RST : flags_q) | {peNow, feNow, oveNow};
      rxDoneIrq_q <= frameEnd & (~anyErr | mode_q[`UMES_ISRM_BIT]);
      rxErrIrq_q  <= frameEnd & anyErr & ~mode_q[`UMES_ISRM_BIT];
    end
  end

  // transmitter: buffer, framing and line
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txBuf_q     <= `UMES_BUF_RST;
      txBufFull_q <= 1'b0;
      txState_q   <= S_IDLE;
      txCnt_q     <= 8'h00;
      txBit_q     <= 3'h0;
      txShift_q   <= 8'h00;
      txPar_q     <= 1'b0;
      txStop_q    <= 1'b0;
      txLine_q    <= 1'b1;
      txDoneIrq_q <= 1'b0;
    end else if (!txOn) begin
      if (!gateOn) txBuf_q <= `UMES_BUF_RST;
      txBufFull_q <= 1'b0;
      txState_q   <= S_IDLE;
      txLine_q    <= 1'b1;
      txDoneIrq_q <= 1'b0;
    end else begin
      txDoneIrq_q <= 1'b0;
      if (txbWrite) begin
        txBuf_q     <= wData_q;
        txBufFull_q <= 1'b1;
      end
      case (txState_q)
        S_IDLE: begin
          if (txBufFull_q) begin
            txShift_q   <= len8 ? txBuf_q : {1'b0, txBuf_q[6:0]};
            txPar_q     <= parSel[1] & (^(len8 ? txBuf_q : {1'b0, txBuf_q[6:0]}) ^ ~parSel[0]);
            txBufFull_q <= txbWrite;
            txCnt_q     <= 8'h00;
            txLine_q    <= 1'b0;
            txState_q   <= S_START;
          end
        end
        default: begin
          if (baseTick) begin
            if (txCnt_q != OVS_M1) txCnt_q <= txCnt_q + 8'h01;
            else begin
              txCnt_q <= 8'h00;
              case (txState_q)
                S_START: begin
                  txLine_q  <= txShift_q[0];
                  txShift_q <= {1'b1, txShift_q[7:1]};
                  txBit_q   <= 3'h0;
                  txState_q <= S_DATA;
                end
                S_DATA: begin
                  if (txBit_q == lastBit) begin
                    txStop_q  <= 1'b0;
                    txLine_q  <= (parSel == 2'h0) ? 1'b1 : txPar_q;
                    txState_q <= (parSel == 2'h0) ? S_STOP : S_PAR;
                  end else begin
                    txLine_q  <= txShift_q[0];
                    txShift_q <= {1'b1, txShift_q[7:1]};
                    txBit_q   <= txBit_q + 3'h1;
                  end
                end
                S_PAR: begin
                  txLine_q  <= 1'b1;
                  txStop_q  <= 1'b0;
                  txState_q <= S_STOP;
                end
                default: begin
                  if (txStop_q == mode_q[`UMES_SL_BIT]) begin
                    txState_q   <= S_IDLE;
                    txDoneIrq_q <= 1'b1;
                  end else txStop_q <= 1'b1;
                end
              endcase
            end
          end
        end
      endcase
    end
  end

  // line is forced high the moment transmission is off
  assign serialOutPin        = txOn ? txLine_q : 1'b1;
  assign receiveCompleteIrq  = rxDoneIrq_q;
  assign receiveErrorIrq     = rxErrIrq_q;
  assign transmitCompleteIrq = txDoneIrq_q;

endmodule

// ==== dv/umes_channel_properties.sv ====
// checker for the bus, serial output and event ports of one channel
// assumes a bind into umes_channel, single clk domain
`timescale 1ns/1ns
module umes_channel_properties #(
  parameter ADDR_W = 8
) (
  // system
  input wire logic              clk,
  input wire logic              resetn,
  // register bus
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [31:0]       s_axi_rdata,
  // serial and events
  input wire logic              serialOutPin,
  input wire logic              receiveCompleteIrq,
  input wire logic              receiveErrorIrq,
  input wire logic              transmitCompleteIrq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [ADDR_W-1:0] wrAddr_q, rdAddr_q;
  logic [7:0]        wrData_q, mode_q;
  logic              bPrev_q;
  logic              wrStrb_q;
  // shadow of the mode register, one cycle behind the commit
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrAddr_q <= '0;
      rdAddr_q <= '0;
      wrData_q <= 8'h00;
      mode_q   <= 8'h01;
      bPrev_q  <= 1'b0;
      wrStrb_q <= 1'b0;
    end else begin
      bPrev_q <= s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) wrAddr_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) begin
        wrData_q <= s_axi_wdata[7:0];
        wrStrb_q <= s_axi_wstrb[0];
      end
      if (s_axi_arvalid && s_axi_arready) rdAddr_q <= s_axi_araddr;
      // byte 0 strobe off leaves the mode register alone
      if (s_axi_bvalid && !bPrev_q && wrAddr_q == 'h00 && wrStrb_q) mode_q <= wrData_q;
    end
  end
  a_txd_idle_high: assert property (!mode_q[6] |-> serialOutPin)
    else $error("serial out low while transmit disabled");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  a_mode_readback: assert property (s_axi_rvalid && rdAddr_q == 'h00 |->
    s_axi_rdata == {24'h0, mode_q}) else $error("mode read differs from write");
  a_flags_width: assert property (s_axi_rvalid && rdAddr_q == 'h0C |->
    s_axi_rdata[31:3] == 0) else $error("flag register unused bits set");
  a_buf_gate_off: assert property (s_axi_rvalid && rdAddr_q == 'h08 &&
    !mode_q[7] |-> s_axi_rdata[7:0] == 8'hFF) else $error("buffer not ff with gate off");
  a_irq_exclusive: assert property (!(receiveCompleteIrq && receiveErrorIrq))
    else $error("both receive events at once");
  a_rx_quiet: assert property (!mode_q[5] |-> !receiveCompleteIrq &&
    !receiveErrorIrq) else $error("receive event while reception disabled");
  a_rc_pulse: assert property (receiveCompleteIrq |=> !receiveCompleteIrq)
    else $error("complete event longer than one cycle");
  // main scenarios reached
  c_rc: cover property ($rose(receiveCompleteIrq));
  c_re: cover property ($rose(receiveErrorIrq));
  c_tc: cover property ($rose(transmitCompleteIrq));
endmodule
bind umes_channel umes_channel_properties #(.ADDR_W(ADDR_W)) i_umes_channel_properties (.*);

// ==== dv/umes_remote.sv ====
// remote serial device: sends frames to the channel, captures its output
// assumes bit time of OVS base ticks, ticks in the clk domain
`timescale 1ns/1ns
module umes_remote #(
  parameter OVS = 4
) (
  // clocking
  input wire logic clk,
  input wire logic baseTick,
  // serial lines
  input wire logic txLine,
  output logic     rxLine
);
  // line idles high so enabling never starts a false reception
  initial rxLine = 1'b1;
  task automatic waitTicks(input int k);
    repeat (k) @(posedge clk iff baseTick);
  endtask
  // send n bits lsb first, one stop level appended by caller
  task automatic sendFrame(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rxLine <= f[i];
      waitTicks(OVS);
    end
    rxLine <= 1'b1;
  endtask
  // wait for a start edge, then sample mid-bit
  task automatic recvFrame(output logic [11:0] f, input int n);
    int t;
    f = '0;
    t = 0;
    while (txLine !== 1'b0 && t < 4000) begin
      @(posedge clk);
      t++;
    end
    waitTicks(OVS / 2);
    for (int i = 0; i < n; i++) begin
      f[i] = txLine;
      waitTicks(OVS);
    end
  endtask
endmodule

// ==== dv/umes_testbench.sv ====
// self-checking bench for one serial channel with a remote device model
// assumes map: mode 00h, tx buffer 04h, rx buffer 08h, flags 0ch
`timescale 1ns/1ns
`include "umes_map.vh"
module testbench;
  logic        clk = 0, resetn = 0, baseTick = 0, seenRc = 0, seenRe = 0, seenTc = 0;
  logic        awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
  logic [7:0]  awAddr = 0, arAddr = 0;
  logic [31:0] wData = 0;
  logic [3:0]  wStrb = 4'h1;
  logic [1:0]  lastBResp = 0;
  wire         awReady, wReady, bValid, arReady, rValid, txd, rxd, rcIrq, reIrq, tcIrq;
  wire  [1:0]  bResp, rResp;
  wire  [31:0] rData;
  int          failures = 0, tests_run = 0;
  // clock and base tick at half the clock rate
  always #20 clk = ~clk;
  always @(posedge clk) baseTick <= ~baseTick;
  // sticky event capture
  always @(posedge clk) begin
    if (rcIrq) seenRc <= 1;
    if (reIrq) seenRe <= 1;
    if (tcIrq) seenTc <= 1;
  end
  umes_channel #(.OVS(4)) i_umes_channel (.clk(clk), .resetn(resetn), .baseTick(baseTick),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_awaddr(awAddr),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_bresp(bResp), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_araddr(arAddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid_unused_n(1'b0), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .serialInPin(rxd), .serialOutPin(txd),
    .receiveCompleteIrq(rcIrq), .receiveErrorIrq(reIrq), .transmitCompleteIrq(tcIrq));
  umes_remote #(.OVS(4)) i_umes_remote (.clk(clk), .baseTick(baseTick), .txLine(txd),
    .rxLine(rxd));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    if (failures == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ready sampled at the falling edge, where it is settled
  task automatic axiWrite(input logic [7:0] a, input logic [7:0] d);
    logic ah, wh, bh;
    @(posedge clk);
    awAddr <= a; wData <= {24'h0, d}; awValid <= 1; wValid <= 1; bReady <= 1;
    do begin
      @(negedge clk);
      ah = awValid & awReady; wh = wValid & wReady; bh = bValid & bReady;
      lastBResp = bResp;
      @(posedge clk);
      if (ah) awValid <= 0;
      if (wh) wValid <= 0;
      if (bh) bReady <= 0;
    end while (!bh);
  endtask
  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, rh;
    @(posedge clk);
    arAddr <= a; arValid <= 1; rReady <= 1;
    do begin
      @(negedge clk);
      ah = arValid & arReady; rh = rValid & rReady; d = rData; r = rResp;
      @(posedge clk);
      if (ah) arValid <= 0;
      if (rh) rReady <= 0;
    end while (!rh);
  endtask
  task automatic readChk(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] v;
    logic [1:0]  r;
    axiRead(a, v, r);
    chk(nm, v, e);
  endtask
  function automatic logic [11:0] mkFrame(input logic [7:0] d, input logic [1:0] p,
      input logic cl, input logic sl, output int n);
    logic [7:0] dd;
    mkFrame = '0;
    dd = cl ? d : {1'b0, d[6:0]};
    n = cl ? 9 : 8;
    mkFrame[8:1] = dd;
    if (p != 0) mkFrame[n++] = (p == 1) ? 1'b0 : (p == 2) ? ~^dd : ^dd;
    mkFrame[n++] = 1'b1;
    if (sl) mkFrame[n++] = 1'b1;
  endfunction
  // units off, two base clocks, then gate plus requested enables
  task automatic setMode(input logic [7:0] fmt, input logic [7:0] en);
    axiWrite(8'h00, 8'h80 | fmt);
    i_umes_remote.waitTicks(2);
    axiWrite(8'h00, 8'h80 | en | fmt);
  endtask
  task automatic rxCheck(input logic [7:0] fmt, d, input logic bp, bs,
      input logic [7:0] eb, input logic [2:0] ef, input logic erc, ere);
    int n;
    logic [11:0] f;
    setMode(fmt, 8'h20);
    f = mkFrame(d, fmt[4:3], fmt[2], 1'b0, n);
    if (bp) f[n-2] = ~f[n-2];
    if (bs) f[n-1] = 1'b0;
    seenRc <= 0;
    seenRe <= 0;
    i_umes_remote.sendFrame(f, n);
    repeat (20) @(posedge clk);
    readChk(8'h0C, {29'h0, ef}, "flags");
    readChk(8'h08, {24'h0, eb}, "buffer");
    chk("complete event", seenRc, erc);
    chk("error event", seenRe, ere);
  endtask
  task automatic t_reset();
    logic [31:0] v;
    logic [1:0]  r;
    readChk(8'h00, 32'h0000_0001, "mode");
    readChk(8'h0C, 32'h0000_0000, "flags");
    readChk(8'h08, 32'h0000_00FF, "buffer");
    // write with byte 0 strobe off is answered but ignored
    wStrb <= 4'h0;
    axiWrite(8'h00, 8'hE0);
    wStrb <= 4'h1;
    chk("masked write resp", lastBResp, `UMES_RESP_OKAY);
    readChk(8'h00, 32'h0000_0001, "mode after masked write");
    axiWrite(8'h30, 8'h00);
    chk("unmapped write resp", lastBResp, `UMES_RESP_SLVERR);
    axiRead(8'h30, v, r);
    chk("unmapped resp", r, `UMES_RESP_SLVERR);
    chk("serial out", txd, 1'b1);
  endtask
  task automatic t_tx();
    logic [11:0] got, f;
    int n;
    setMode(8'h00, 8'h00);
    seenTc <= 0;
    axiWrite(8'h04, 8'h5A);
    repeat (200) @(posedge clk);
    chk("tx while off", seenTc, 1'b0);
    readChk(8'h04, 32'h0000_00FF, "tx buffer ignored");
    for (int p = 0; p < 4; p++) begin
      setMode({3'b0, p[1:0], p[1], p[0], 1'b0}, 8'h40);
      f = mkFrame(8'hB3 + 8'(p), p[1:0], p[1], p[0], n);
      seenTc <= 0;
      fork
        i_umes_remote.recvFrame(got, n);
        axiWrite(8'h04, 8'hB3 + 8'(p));
      join
      repeat (40) @(posedge clk);
      chk("tx frame", got, f);
      chk("tx done", seenTc, 1'b1);
    end
  endtask
  task automatic t_overrun();
    int n;
    logic [11:0] f;
    setMode(8'h1C, 8'h20);
    f = mkFrame(8'h3C, 2'd3, 1'b1, 1'b0, n);
    i_umes_remote.sendFrame(f, n);
    f = mkFrame(8'h81, 2'd3, 1'b1, 1'b0, n);
    i_umes_remote.sendFrame(f, n);
    repeat (20) @(posedge clk);
    readChk(8'h0C, 32'h0000_0001, "overrun flag");
    readChk(8'h08, 32'h0000_003C, "kept buffer");
  endtask
  task automatic t_rx_off();
    int n;
    logic [11:0] f;
    setMode(8'h1C, 8'h00);
    seenRc <= 0;
    f = mkFrame(8'h44, 2'd3, 1'b1, 1'b0, n);
    i_umes_remote.sendFrame(f, n);
    repeat (20) @(posedge clk);
    readChk(8'h08, 32'h0000_003C, "retained buffer");
    chk("no event", seenRc, 1'b0);
  endtask
  task automatic t_clear();
    int n;
    logic [11:0] f;
    rxCheck(8'h1C, 8'h35, 1, 0, 8'h35, 3'h4, 0, 1);
    rxCheck(8'h11, 8'hA5, 1, 0, 8'h25, 3'h4, 1, 0);
    // leave a parity error unread so only the disable can clear it
    setMode(8'h1C, 8'h20);
    f = mkFrame(8'h35, 2'd3, 1'b1, 1'b0, n);
    f[n-2] = ~f[n-2];
    i_umes_remote.sendFrame(f, n);
    repeat (20) @(posedge clk);
    axiWrite(8'h00, 8'h9C);
    readChk(8'h0C, 32'h0000_0000, "flags after rx off");
    axiWrite(8'h00, 8'h1C);
    readChk(8'h08, 32'h0000_00FF, "buffer gate off");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1;
    t_reset();
    t_tx();
    rxCheck(8'h1E, 8'hC6, 0, 0, 8'hC6, 3'h0, 1, 0);
    rxCheck(8'h14, 8'h35, 1, 0, 8'h35, 3'h4, 0, 1);
    readChk(8'h0C, 32'h0000_0000, "flags reread");
    rxCheck(8'h15, 8'h35, 1, 0, 8'h35, 3'h4, 1, 0);
    rxCheck(8'h0C, 8'h71, 1, 0, 8'h71, 3'h0, 1, 0);
    rxCheck(8'h00, 8'hF3, 0, 1, 8'h73, 3'h2, 0, 1);
    t_overrun();
    t_rx_off();
    t_clear();
    results();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    results();
  end
endmodule
